// File: mci_map.vh
// Command numbers, interrupt numbers and layout constants of the command core
`ifndef MCI_MAP_VH
`define MCI_MAP_VH
`define MCI_CMD_ROR 8'h01
`define MCI_CMD_ROL 8'h02
`define MCI_CMD_MST 8'h03
`define MCI_CMD_MVP 8'h04
`define MCI_CMD_SAP 8'h05
`define MCI_CMD_GAP 8'h06
`define MCI_CMD_SGP 8'h09
`define MCI_CMD_GGP 8'h0A
`define MCI_CMD_GLOBAL_PARAM_SAVE 8'h0B
`define MCI_CMD_GLOBAL_PARAM_RELOAD 8'h0C
`define MCI_CMD_OUTW 8'h0E
`define MCI_CMD_INR 8'h0F
`define MCI_CMD_ARITH_WITH_CONSTANT 8'h13
`define MCI_CMD_COMP 8'h14
`define MCI_CMD_JC 8'h15
`define MCI_CMD_JA 8'h16
`define MCI_CMD_SUBROUTINE_CALL 8'h17
`define MCI_CMD_SUBROUTINE_RETURN 8'h18
`define MCI_CMD_EI 8'h19
`define MCI_CMD_DI 8'h1A
`define MCI_CMD_WAIT 8'h1B
`define MCI_CMD_STOP 8'h1C
`define MCI_CMD_SCO 8'h1E
`define MCI_CMD_GCO 8'h1F
`define MCI_CMD_CCO 8'h20
`define MCI_CMD_ARITH_WITH_X 8'h21
`define MCI_CMD_AAP 8'h22
`define MCI_CMD_AGP 8'h23
`define MCI_CMD_SET_HANDLER_ADDRESS 8'h25
`define MCI_CMD_HANDLER_RETURN 8'h26
`define MCI_CMD_ACO 8'h27
`define MCI_CMD_ROLX 8'h34
`define MCI_CMD_RORX 8'h35
`define MCI_CMD_MOTOR_HALT_INDEXED 8'h36
`define MCI_CMD_SIV 8'h37
`define MCI_CMD_GIV 8'h38
`define MCI_CMD_AIV 8'h39
`define MCI_IRQ_GLOBAL 8'hFF
`define MCI_NUM_SRC 22
// Arith_with_constant operations
`define MCI_OP_ADD 4'h0
`define MCI_OP_SUB 4'h1
`define MCI_OP_AND 4'h2
`define MCI_OP_OR 4'h3
`define MCI_OP_XOR 4'h4
`define MCI_OP_NOT 4'h5
`define MCI_OP_LOAD 4'h6
`define MCI_OP_TOX 4'h7
// Action codes
`define MCI_ACT_NONE 5'h00
`define MCI_ACT_ROR 5'h01
`define MCI_ACT_ROL 5'h02
`define MCI_ACT_MST 5'h03
`define MCI_ACT_MVP 5'h04
`define MCI_ACT_SAP 5'h05
`define MCI_ACT_GAP 5'h06
`define MCI_ACT_SGP 5'h07
`define MCI_ACT_GGP 5'h08
`define MCI_ACT_GLOBAL_PARAM_SAVE 5'h09
`define MCI_ACT_GLOBAL_PARAM_RELOAD 5'h0A
`define MCI_ACT_OUTW 5'h0B
`define MCI_ACT_INR 5'h0C
`define MCI_ACT_SCO 5'h0D
`define MCI_ACT_GCO 5'h0E
`define MCI_ACT_CCO 5'h0F
`define MCI_ACT_AAP 5'h10
`define MCI_ACT_AGP 5'h11
`define MCI_ACT_ACO 5'h12
`define MCI_ACT_JUMP 5'h13
`define MCI_ACT_CALL 5'h14
`define MCI_ACT_RET 5'h15
`define MCI_ACT_WAIT 5'h16
`define MCI_ACT_STOP 5'h17
`define MCI_ACT_IRQ 5'h18
`define MCI_ACT_BADCMD 5'h1F
`endif

// File: mci_core.v
// Command decoder, accumulator/X unit and interrupt dispatcher of the motion core
// How it works
// - 52 rotates left, accu velocity, X axis
// - 53 rotates right, accu velocity, X axis
// - 54 stops axis indexed by X
// - 55/56/57 indexed var write, read, accu copy
// - Motion commands 1,2,3,4,30,31,32 both modes
// - Axis params 5,6; global 9,10,11,12
// - Branches 22,21,20,23,24,27,28 for programs
// - Output write 14, input read 15
// - Arith_with_constant 19,33; accu copies 34,35,39
// - Program reads land in accumulator
// - X register loadable from accumulator
// - Direct-mode reads leave accumulator untouched
// - Irq enable 25, disable 26, vector 37, return 38
// - One handler vector per interrupt number
// - Irq 0-2 timers, 3-5 position reached
// - Irq 15-17 stall, 21-23 deviation
// - Irq 27-32 stop switches, left/right alternating
// - Irq 39-42 input change, 255 global
// - Dispatch needs pending, enabled, vector valid
// - Save accu, X, flags before handler
// - No nesting while handler runs
// - Handler return restores context, resumes program
`timescale 1ns/1ns
`default_nettype none
`include "mci_map.vh"
module mci_core #(
    parameter AW = 16,
    parameter NVAR = 16
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire RESETN,
    // Command in
    input wire CMD_VALID,
    input wire CMD_PROGRAM,
    input wire [7:0] CMD_NUM,
    input wire [7:0] CMD_TYPE,
    input wire [7:0] CMD_BANK,
    input wire [31:0] CMD_VALUE,
    input wire [AW-1:0] CMD_PC,
    // Read data returned by motion side
    input wire RD_VALID,
    input wire [31:0] RD_DATA,
    // Interrupt events, one pulse per source
    input wire [`MCI_NUM_SRC-1:0] IRQ_EVENT,
    // Action out
    output reg ACT_VALID,
    output reg [4:0] ACT_CODE,
    output reg [7:0] ACT_TYPE,
    output reg [7:0] ACT_AXIS,
    output reg [31:0] ACT_VALUE,
    output reg [AW-1:0] ACT_ADDR,
    // Reply for host
    output reg REPLY_VALID,
    output reg [31:0] REPLY_DATA,
    // Program state
    output reg [31:0] ACCU,
    output reg [31:0] XREG,
    output reg [1:0] FLAGS,
    output reg IN_HANDLER
);
    // Map an interrupt number to source slot; 5'h1F means unassigned
    function [4:0] irq_slot;
        input [7:0] n;
        begin
            if (n <= 8'h05) irq_slot = n[4:0];
            else if (n >= 8'h0F && n <= 8'h11) irq_slot = n[4:0] - 5'd9;
            else if (n >= 8'h15 && n <= 8'h17) irq_slot = n[4:0] - 5'd12;
            else if (n >= 8'h1B && n <= 8'h20) irq_slot = n[4:0] - 5'd15;
            else if (n >= 8'h27 && n <= 8'h2A) irq_slot = n[4:0] - 5'd21;
            else irq_slot = 5'h1F;
        end
    endfunction

    function [31:0] alu;
        input [3:0] op;
        input [31:0] a;
        input [31:0] b;
        begin
            case (op)
                `MCI_OP_ADD: alu = a + b;
                `MCI_OP_SUB: alu = a - b;
                `MCI_OP_AND: alu = a & b;
                `MCI_OP_OR: alu = a | b;
                `MCI_OP_XOR: alu = a ^ b;
                `MCI_OP_NOT: alu = ~a;
                `MCI_OP_LOAD: alu = b;
                default: alu = a;
            endcase
        end
    endfunction

    reg [`MCI_NUM_SRC-1:0] pending;
    reg [`MCI_NUM_SRC-1:0] enabled;
    reg [`MCI_NUM_SRC-1:0] vec_valid;
    reg [AW-1:0] vector [0:`MCI_NUM_SRC-1];
    reg global_en;
    reg [31:0] save_accu;
    reg [31:0] save_x;
    reg [1:0] save_flags;
    reg [AW-1:0] save_pc;
    reg [31:0] ivar [0:NVAR-1];
    reg read_to_accu;
    reg [4:0] slot;
    reg [4:0] take;
    reg take_ok;
    reg [31:0] arith_with_constant;
    integer i;
    integer j;

    always @* begin
        slot = irq_slot(CMD_TYPE);
        take = 5'd0;
        take_ok = 1'b0;
        for (i = `MCI_NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (pending[i] && enabled[i] && vec_valid[i]) begin
                take = i[4:0];
                take_ok = 1'b1;
            end
        end
        arith_with_constant = alu(CMD_TYPE[3:0], ACCU, CMD_VALUE);
    end

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pending <= {`MCI_NUM_SRC{1'b0}};
            enabled <= {`MCI_NUM_SRC{1'b0}};
            vec_valid <= {`MCI_NUM_SRC{1'b0}};
            global_en <= 1'b0;
            save_accu <= 32'h0000_0000;
            save_x <= 32'h0000_0000;
            save_flags <= 2'b00;
            save_pc <= {AW{1'b0}};
            read_to_accu <= 1'b0;
            ACT_VALID <= 1'b0;
            ACT_CODE <= `MCI_ACT_NONE;
            ACT_TYPE <= 8'h00;
            ACT_AXIS <= 8'h00;
            ACT_VALUE <= 32'h0000_0000;
            ACT_ADDR <= {AW{1'b0}};
            REPLY_VALID <= 1'b0;
            REPLY_DATA <= 32'h0000_0000;
            ACCU <= 32'h0000_0000;
            XREG <= 32'h0000_0000;
            FLAGS <= 2'b00;
            IN_HANDLER <= 1'b0;
        end else begin
            ACT_VALID <= 1'b0;
            REPLY_VALID <= 1'b0;
            // Dispatch only between program commands, never inside a handler
            if (global_en && !IN_HANDLER && take_ok && !CMD_VALID) begin
                // A read landing now belongs to the main program's context
                save_accu <= (RD_VALID && read_to_accu) ? RD_DATA : ACCU;
                save_x <= XREG;
                save_flags <= FLAGS;
                save_pc <= CMD_PC;
                IN_HANDLER <= 1'b1;
                ACT_VALID <= 1'b1;
                ACT_CODE <= `MCI_ACT_IRQ;
                ACT_TYPE <= {3'b000, take};
                ACT_ADDR <= vector[take];
            end else if (CMD_VALID) begin
                ACT_VALID <= 1'b1;
                ACT_CODE <= `MCI_ACT_NONE;
                ACT_TYPE <= CMD_TYPE;
                ACT_AXIS <= CMD_BANK;
                ACT_VALUE <= CMD_VALUE;
                ACT_ADDR <= CMD_VALUE[AW-1:0];
                REPLY_VALID <= 1'b1;
                REPLY_DATA <= 32'h0000_0000;
                case (CMD_NUM)
                    `MCI_CMD_ROR: ACT_CODE <= `MCI_ACT_ROR;
                    `MCI_CMD_ROL: ACT_CODE <= `MCI_ACT_ROL;
                    `MCI_CMD_MST: ACT_CODE <= `MCI_ACT_MST;
                    `MCI_CMD_MVP: ACT_CODE <= `MCI_ACT_MVP;
                    `MCI_CMD_SCO: ACT_CODE <= `MCI_ACT_SCO;
                    `MCI_CMD_CCO: ACT_CODE <= `MCI_ACT_CCO;
                    `MCI_CMD_SAP: ACT_CODE <= `MCI_ACT_SAP;
                    `MCI_CMD_SGP: ACT_CODE <= `MCI_ACT_SGP;
                    `MCI_CMD_GLOBAL_PARAM_SAVE: ACT_CODE <= `MCI_ACT_GLOBAL_PARAM_SAVE;
                    `MCI_CMD_GLOBAL_PARAM_RELOAD: ACT_CODE <= `MCI_ACT_GLOBAL_PARAM_RELOAD;
                    `MCI_CMD_OUTW: ACT_CODE <= `MCI_ACT_OUTW;
                    `MCI_CMD_GCO, `MCI_CMD_GAP, `MCI_CMD_GGP, `MCI_CMD_INR: begin
                        case (CMD_NUM)
                            `MCI_CMD_GCO: ACT_CODE <= `MCI_ACT_GCO;
                            `MCI_CMD_GAP: ACT_CODE <= `MCI_ACT_GAP;
                            `MCI_CMD_GGP: ACT_CODE <= `MCI_ACT_GGP;
                            default: ACT_CODE <= `MCI_ACT_INR;
                        endcase
                        // Host queries must not disturb a running program
                        read_to_accu <= CMD_PROGRAM;
                        REPLY_VALID <= 1'b0;
                    end
                    `MCI_CMD_ROLX: begin
                        ACT_CODE <= `MCI_ACT_ROL;
                        ACT_VALUE <= ACCU;
                        ACT_AXIS <= XREG[7:0];
                    end
                    `MCI_CMD_RORX: begin
                        ACT_CODE <= `MCI_ACT_ROR;
                        ACT_VALUE <= ACCU;
                        ACT_AXIS <= XREG[7:0];
                    end
                    `MCI_CMD_MOTOR_HALT_INDEXED: begin
                        ACT_CODE <= `MCI_ACT_MST;
                        ACT_AXIS <= XREG[7:0];
                    end
                    `MCI_CMD_SIV: ivar[XREG[3:0]] <= CMD_VALUE;
                    `MCI_CMD_AIV: ivar[XREG[3:0]] <= ACCU;
                    `MCI_CMD_GIV: begin
                        REPLY_DATA <= ivar[XREG[3:0]];
                        if (CMD_PROGRAM) ACCU <= ivar[XREG[3:0]];
                    end
                    `MCI_CMD_ARITH_WITH_CONSTANT: begin
                        if (CMD_TYPE[3:0] == `MCI_OP_TOX) XREG <= ACCU;
                        else ACCU <= arith_with_constant;
                    end
                    `MCI_CMD_ARITH_WITH_X: begin
                        if (CMD_TYPE[3:0] == `MCI_OP_TOX) XREG <= ACCU;
                        else ACCU <= alu(CMD_TYPE[3:0], ACCU, XREG);
                    end
                    `MCI_CMD_AAP: begin
                        ACT_CODE <= `MCI_ACT_AAP;
                        ACT_VALUE <= ACCU;
                    end
                    `MCI_CMD_AGP: begin
                        ACT_CODE <= `MCI_ACT_AGP;
                        ACT_VALUE <= ACCU;
                    end
                    `MCI_CMD_ACO: begin
                        ACT_CODE <= `MCI_ACT_ACO;
                        ACT_VALUE <= ACCU;
                    end
                    `MCI_CMD_COMP: begin
                        FLAGS[0] <= (ACCU == CMD_VALUE);
                        FLAGS[1] <= ($signed(ACCU) < $signed(CMD_VALUE));
                    end
                    `MCI_CMD_JA: ACT_CODE <= `MCI_ACT_JUMP;
                    `MCI_CMD_JC: ACT_CODE <= `MCI_ACT_JUMP;
                    `MCI_CMD_SUBROUTINE_CALL: ACT_CODE <= `MCI_ACT_CALL;
                    `MCI_CMD_SUBROUTINE_RETURN: ACT_CODE <= `MCI_ACT_RET;
                    `MCI_CMD_WAIT: ACT_CODE <= `MCI_ACT_WAIT;
                    `MCI_CMD_STOP: ACT_CODE <= `MCI_ACT_STOP;
                    `MCI_CMD_EI: begin
                        if (CMD_TYPE == `MCI_IRQ_GLOBAL) global_en <= 1'b1;
                        else if (slot != 5'h1F) enabled[slot] <= 1'b1;
                    end
                    `MCI_CMD_DI: begin
                        if (CMD_TYPE == `MCI_IRQ_GLOBAL) global_en <= 1'b0;
                        else if (slot != 5'h1F) enabled[slot] <= 1'b0;
                    end
                    `MCI_CMD_SET_HANDLER_ADDRESS: begin
                        if (slot != 5'h1F) begin
                            vector[slot] <= CMD_VALUE[AW-1:0];
                            vec_valid[slot] <= 1'b1;
                        end
                    end
                    `MCI_CMD_HANDLER_RETURN: begin
                        if (IN_HANDLER) begin
                            ACCU <= save_accu;
                            XREG <= save_x;
                            FLAGS <= save_flags;
                            IN_HANDLER <= 1'b0;
                            ACT_CODE <= `MCI_ACT_JUMP;
                            ACT_ADDR <= save_pc;
                        end
                    end
                    default: ACT_CODE <= `MCI_ACT_BADCMD;
                endcase
            end
            // Jump flag semantics left to the motion side: it reads FLAGS
            if (RD_VALID) begin
                REPLY_VALID <= 1'b1;
                REPLY_DATA <= RD_DATA;
                if (read_to_accu) ACCU <= RD_DATA;
                read_to_accu <= 1'b0;
            end
            // Set beats clear for same-cycle event
            for (j = 0; j < `MCI_NUM_SRC; j = j + 1) begin
                if (IRQ_EVENT[j]) pending[j] <= 1'b1;
                else if (global_en && !IN_HANDLER && take_ok && !CMD_VALID && take == j)
                    pending[j] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: mci_core_asserts.sv
// Concurrent checks on the motion command core
`timescale 1ns/1ns
`default_nettype none
`include "mci_map.vh"
module mci_chk (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Command and read return
    input wire logic CMD_VALID,
    input wire logic CMD_PROGRAM,
    input wire logic [7:0] CMD_NUM,
    input wire logic [7:0] CMD_TYPE,
    input wire logic RD_VALID,
    input wire logic [31:0] RD_DATA,
    // Results
    input wire logic ACT_VALID,
    input wire logic [4:0] ACT_CODE,
    input wire logic [7:0] ACT_TYPE,
    input wire logic [7:0] ACT_AXIS,
    input wire logic [31:0] ACT_VALUE,
    input wire logic [31:0] ACCU,
    input wire logic [31:0] XREG,
    input wire logic [1:0] FLAGS,
    input wire logic IN_HANDLER
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    logic rd_prog;
    logic [65:0] ctx;
    wire rd_cmd = CMD_VALID && (CMD_NUM == 8'h06 || CMD_NUM == 8'h0A
        || CMD_NUM == 8'h0F || CMD_NUM == 8'h1F);
    wire irq_act = ACT_VALID && ACT_CODE == `MCI_ACT_IRQ;
    // Context as the main program left it, seen while the dispatch action shows
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_prog <= 1'h0;
            ctx <= 66'h0;
        end else begin
            if (rd_cmd) begin
                rd_prog <= CMD_PROGRAM;
            end
            if (irq_act) begin
                ctx <= {ACCU, XREG, FLAGS};
            end
        end
    end
    rotl_index_a: assert property (CMD_VALID && CMD_NUM == 8'h34 |=> ACT_VALID
        && ACT_CODE == `MCI_ACT_ROL && ACT_VALUE == $past(ACCU) && ACT_AXIS == $past(XREG[7:0]))
        else $error("indexed rotate left wrong");
    rotr_index_a: assert property (CMD_VALID && CMD_NUM == 8'h35 |=> ACT_VALID
        && ACT_CODE == `MCI_ACT_ROR && ACT_VALUE == $past(ACCU) && ACT_AXIS == $past(XREG[7:0]))
        else $error("indexed rotate right wrong");
    halt_index_a: assert property (CMD_VALID && CMD_NUM == 8'h36 |=> ACT_VALID
        && ACT_CODE == `MCI_ACT_MST && ACT_AXIS == $past(XREG[7:0]))
        else $error("indexed halt wrong");
    x_load_a: assert property (CMD_VALID && CMD_NUM == 8'h13 && CMD_TYPE[3:0] == 4'h7
        |=> XREG == $past(ACCU)) else $error("X not loaded from accumulator");
    prog_read_a: assert property (RD_VALID && rd_prog && !CMD_VALID
        |=> ACCU == $past(RD_DATA)) else $error("program read missed accumulator");
    host_read_a: assert property (RD_VALID && !rd_prog && !CMD_VALID
        |=> $stable(ACCU)) else $error("host read disturbed accumulator");
    irq_enter_a: assert property (irq_act |-> IN_HANDLER && !$past(IN_HANDLER)
        && !$past(CMD_VALID) && ACT_TYPE < 8'h16) else $error("bad handler entry");
    no_nest_a: assert property (IN_HANDLER |=> !irq_act)
        else $error("nested handler entry");
    ctx_restore_a: assert property (CMD_VALID && CMD_NUM == 8'h26 && IN_HANDLER
        |=> !IN_HANDLER && ACT_CODE == `MCI_ACT_JUMP && {ACCU, XREG, FLAGS} == ctx)
        else $error("context not restored");
    cover property (irq_act);
    cover property (CMD_VALID && CMD_NUM == 8'h26 && IN_HANDLER);
    cover property (RD_VALID && rd_prog);
endmodule
bind mci_core mci_chk chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID),
    .CMD_PROGRAM(CMD_PROGRAM), .CMD_NUM(CMD_NUM), .CMD_TYPE(CMD_TYPE), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .ACT_VALID(ACT_VALID), .ACT_CODE(ACT_CODE), .ACT_TYPE(ACT_TYPE),
    .ACT_AXIS(ACT_AXIS), .ACT_VALUE(ACT_VALUE), .ACCU(ACCU), .XREG(XREG), .FLAGS(FLAGS),
    .IN_HANDLER(IN_HANDLER));
`default_nettype wire

// File: mci_motion_model.sv
// Motion side model answering read actions
`timescale 1ns/1ns
`default_nettype none
`include "mci_map.vh"
module mci_motion_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Answer pace
    input wire logic slow,
    // Action from the core
    input wire logic act_valid,
    input wire logic [4:0] act_code,
    input wire logic [7:0] act_type,
    input wire logic [7:0] act_axis,
    // Read return
    output logic rd_valid,
    output logic [31:0] rd_data
);
    logic [31:0] held;
    integer wait_n;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'h0;
            rd_data <= 32'h0000_0000;
            held <= 32'h0000_0000;
            wait_n <= -1;
        end else begin
            rd_valid <= 1'h0;
            // Idle bus toggles so a stale value never passes
            rd_data <= ~rd_data;
            if (act_valid && (act_code == `MCI_ACT_GAP || act_code == `MCI_ACT_GGP
                || act_code == `MCI_ACT_GCO || act_code == `MCI_ACT_INR)) begin
                held <= {act_type, act_axis, 16'h5AC3};
                wait_n <= slow ? 5 : 0;
            end else if (wait_n == 0) begin
                rd_valid <= 1'h1;
                rd_data <= held;
                wait_n <= -1;
            end else if (wait_n > 0) begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: test_motion_command_interrupt_core.sv
// Self-checking bench for the motion command core
`timescale 1ns/1ns
`default_nettype none
`include "mci_map.vh"
module test_motion_command_interrupt_core;
    logic core_clk;
    logic resetn;
    logic cmd_valid;
    logic cmd_program;
    logic [7:0] cmd_num;
    logic [7:0] cmd_type;
    logic [31:0] cmd_value;
    logic [21:0] irq_event;
    logic slow;
    logic [15:0] cmd_pc;
    wire rd_valid;
    wire act_valid;
    wire reply_valid;
    wire in_handler;
    wire [1:0] flags;
    wire [4:0] act_code;
    wire [7:0] act_type;
    wire [7:0] act_axis;
    wire [15:0] act_addr;
    wire [31:0] rd_data;
    wire [31:0] act_value;
    wire [31:0] reply_data;
    wire [31:0] accu;
    wire [31:0] xreg;
    integer fails;
    integer samples_checked;
    integer s;
    logic [7:0] tcmd [0:24] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A,
        8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h1E, 8'h1F, 8'h20, 8'h22, 8'h23, 8'h27, 8'h16, 8'h17,
        8'h18, 8'h1B, 8'h1C, 8'h15, 8'h0D};
    logic [4:0] tact [0:24] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
        5'h15, 5'h16, 5'h17, 5'h13, 5'h1F};
    mci_core uut (.CORE_CLK(core_clk), .RESETN(resetn), .CMD_VALID(cmd_valid),
        .CMD_PROGRAM(cmd_program), .CMD_NUM(cmd_num), .CMD_TYPE(cmd_type), .CMD_BANK(8'h01),
        .CMD_VALUE(cmd_value), .CMD_PC(cmd_pc), .RD_VALID(rd_valid), .RD_DATA(rd_data),
        .IRQ_EVENT(irq_event), .ACT_VALID(act_valid), .ACT_CODE(act_code),
        .ACT_TYPE(act_type), .ACT_AXIS(act_axis), .ACT_VALUE(act_value), .ACT_ADDR(act_addr),
        .REPLY_VALID(reply_valid), .REPLY_DATA(reply_data), .ACCU(accu), .XREG(xreg),
        .FLAGS(flags), .IN_HANDLER(in_handler));
    mci_motion_model part (.clk(core_clk), .resetn(resetn), .slow(slow),
        .act_valid(act_valid), .act_code(act_code), .act_type(act_type),
        .act_axis(act_axis), .rd_valid(rd_valid), .rd_data(rd_data));
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task send(input logic p, input logic [7:0] n, input logic [7:0] t, input logic [31:0] v);
        @(posedge core_clk);
        cmd_valid <= 1'h1;
        cmd_program <= p;
        cmd_num <= n;
        cmd_type <= t;
        cmd_value <= v;
        // Resume address follows each command so a stale save is visible
        cmd_pc <= {8'h00, n};
        @(posedge core_clk);
        cmd_valid <= 1'h0;
        #1;
    endtask
    // Bounded wait for a reply or a handler entry
    task poll(input logic want_irq);
        integer i;
        for (i = 0; i < 20; i = i + 1) begin
            if (want_irq ? act_valid === 1'h1 && act_code === `MCI_ACT_IRQ : reply_valid === 1'h1)
                break;
            @(posedge core_clk) #1;
        end
    endtask
    task pulse(input logic [21:0] m);
        @(posedge core_clk);
        irq_event <= m;
        @(posedge core_clk);
        irq_event <= 22'h00_0000;
        #1;
    endtask
    function automatic logic [7:0] irqn(input integer k);
        irqn = 8'(k < 6 ? k : k < 9 ? k + 9 : k < 12 ? k + 12 : k < 18 ? k + 15 : k + 21);
    endfunction
    task t_arith_with_constant;
        send(1'h1, 8'h13, 8'h06, 32'h0000_0005);
        send(1'h1, 8'h13, 8'h07, 32'h0000_0000);
        chk(xreg, 32'h0000_0005);
        send(1'h1, 8'h13, 8'h06, 32'h0000_0003);
        send(1'h1, 8'h21, 8'h00, 32'h0000_0000);
        chk(accu, 32'h0000_0008);
        send(1'h1, 8'h13, 8'h01, 32'h0000_0002);
        send(1'h1, 8'h14, 8'h00, 32'h0000_0006);
        chk({accu, flags[0]}, {32'h0000_0006, 1'h1});
        send(1'h1, 8'h13, 8'h04, 32'h0000_000F);
        send(1'h1, 8'h13, 8'h05, 32'h0000_0000);
        chk(accu, 32'hFFFF_FFF6);
        send(1'h1, 8'h13, 8'h02, 32'h0000_00F0);
        send(1'h1, 8'h13, 8'h03, 32'h0000_0003);
        send(1'h1, 8'h14, 8'h00, 32'h0000_0100);
        chk({accu, flags}, {32'h0000_00F3, 2'h2});
    endtask
    task t_index;
        send(1'h1, 8'h13, 8'h06, 32'h0000_0002);
        send(1'h1, 8'h13, 8'h07, 32'h0000_0000);
        send(1'h1, 8'h13, 8'h06, 32'h0001_F400);
        send(1'h1, 8'h34, 8'h00, 32'h0000_0000);
        chk({act_code, act_axis, act_value}, {`MCI_ACT_ROL, 8'h02, 32'h0001_F400});
        send(1'h0, 8'h35, 8'h00, 32'h0000_0000);
        chk({act_code, act_axis, act_value}, {`MCI_ACT_ROR, 8'h02, 32'h0001_F400});
        send(1'h1, 8'h36, 8'h00, 32'h0000_0000);
        chk({act_code, act_axis}, {`MCI_ACT_MST, 8'h02});
    endtask
    task t_table;
        for (s = 0; s < 25; s = s + 1) begin
            send(s > 17, tcmd[s], 8'h00, 32'h0000_0000);
            chk(act_code, tact[s]);
            poll(1'h0);
        end
    endtask
    task t_reads;
        slow <= 1'h1;
        send(1'h1, 8'h06, 8'h03, 32'h0000_0000);
        poll(1'h0);
        chk(accu, 32'h0301_5AC3);
        send(1'h0, 8'h0A, 8'h04, 32'h0000_0000);
        poll(1'h0);
        chk({reply_data, accu}, {32'h0401_5AC3, 32'h0301_5AC3});
        slow <= 1'h0;
    endtask
    task t_ivar;
        send(1'h1, 8'h37, 8'h00, 32'hCAFE_0001);
        send(1'h1, 8'h38, 8'h00, 32'h0000_0000);
        chk(accu, 32'hCAFE_0001);
        send(1'h1, 8'h13, 8'h06, 32'h0000_0077);
        send(1'h1, 8'h39, 8'h00, 32'h0000_0000);
        send(1'h1, 8'h13, 8'h06, 32'h0000_0099);
        send(1'h0, 8'h38, 8'h00, 32'h0000_0000);
        poll(1'h0);
        chk({reply_data, accu}, {32'h0000_0077, 32'h0000_0099});
    endtask
    task t_irq;
        send(1'h1, 8'h19, 8'hFF, 32'h0000_0000);
        for (s = 0; s < 22; s = s + 1) begin
            send(1'h1, 8'h25, irqn(s), 32'h0000_0200 + s);
            send(1'h1, 8'h19, irqn(s), 32'h0000_0000);
            pulse(22'h00_0001 << s);
            poll(1'h1);
            chk({act_type, act_addr}, {8'(s), 16'h0200 + 16'(s)});
            send(1'h1, 8'h13, 8'h06, 32'h0000_0000);
            send(1'h1, 8'h13, 8'h07, 32'h0000_0000);
            send(1'h1, 8'h26, 8'h00, 32'h0000_0000);
            chk({in_handler, act_code, act_addr}, {1'h0, `MCI_ACT_JUMP, 16'h0019});
            chk({accu, xreg}, {32'h0000_0099, 32'h0000_0002});
            send(1'h1, 8'h1A, irqn(s), 32'h0000_0000);
        end
        pulse(22'h00_0020);
        poll(1'h1);
        chk(in_handler, 1'h0);
        send(1'h1, 8'h19, 8'h00, 32'h0000_0000);
        send(1'h1, 8'h19, 8'h01, 32'h0000_0000);
        pulse(22'h00_0003);
        poll(1'h1);
        poll(1'h0);
        chk({in_handler, act_type}, {1'h1, 8'h00});
        send(1'h1, 8'h26, 8'h00, 32'h0000_0000);
        poll(1'h1);
        chk({in_handler, act_type}, {1'h1, 8'h01});
        send(1'h1, 8'h26, 8'h00, 32'h0000_0000);
    endtask
    task finish_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        fails = fails + 1;
        finish_test;
    end
    initial begin
        fails = 0;
        samples_checked = 0;
        resetn = 1'h0;
        cmd_valid = 1'h0;
        cmd_program = 1'h0;
        cmd_num = 8'h00;
        cmd_type = 8'h00;
        cmd_value = 32'h0000_0000;
        irq_event = 22'h00_0000;
        slow = 1'h0;
        cmd_pc = 16'h0000;
        repeat (10) @(posedge core_clk);
        resetn <= 1'h1;
        t_arith_with_constant;
        t_index;
        t_table;
        t_reads;
        t_ivar;
        t_irq;
        finish_test;
    end
endmodule
`default_nettype wire
